/* File: core/rjl_pkg.sv */
// constants and types shared by the register jump-and-link unit
package rjl_pkg;

    // instruction word fields
    localparam int MAJOR_MSB = 31;
    localparam int MAJOR_LSB = 26;
    localparam int LINK_MSB  = 25;
    localparam int LINK_LSB  = 21;
    localparam int SRC_MSB   = 20;
    localparam int SRC_LSB   = 16;
    localparam int MINOR_MSB = 15;
    localparam int MINOR_LSB = 6;
    localparam int SEC_MSB   = 5;
    localparam int SEC_LSB   = 0;

    // encodings
    localparam logic [5:0] MAJOR_OPCODE_GROUP_A = 6'h00;
    localparam logic [5:0] MINOR_EXT_GROUP      = 6'h3c;
    localparam logic [9:0] MINOR_CALL_PLAIN     = 10'h03c;
    localparam logic [9:0] MINOR_CALL_BARRIER   = 10'h07c;

    // return link distance and target bit positions
    localparam logic [31:0] LINK_OFFSET  = 32'h0000_0008;
    localparam int          MODE_BIT     = 0;
    localparam int          ALIGN_BIT    = 1;

    // reset values
    localparam logic        INSTR_SET_SELECT_RESET = 1'h0;
    localparam logic [31:0] ADDR_RESET             = 32'h0000_0000;
    localparam logic [4:0]  SEL_RESET              = 5'h00;

    // control states
    typedef enum logic [0:0] {
        RJL_IDLE,
        RJL_SLOT
    } rjl_state_t;

endpackage : rjl_pkg

/* File: core/rjl_target.sv */
// target address, mode update and address error for a register jump
`timescale 1ns/1ps
module rjl_target (
    input  wire logic [31:0] source_value,
    input  wire logic        second_set_present_cfg,
    input  wire logic        classic_set_present,
    output logic      [31:0] target,
    output logic             mode_load,
    output logic             mode_value,
    output logic             addr_error
);

    always_comb begin
        // [RULE5] full value or cleared bit
        if (second_set_present_cfg == 1'h0) begin
            target    = source_value;
            mode_load = 1'h0;
        end else begin
            // [RULE3] bit zero forced low
            target                  = source_value;
            target[rjl_pkg::MODE_BIT] = 1'h0;
            // [RULE4] mode from bit zero
            mode_load = 1'h1;
        end
        mode_value = source_value[rjl_pkg::MODE_BIT];
        addr_error = 1'h0;
        if (classic_set_present) begin
            // [RULE10] classic target misaligned
            addr_error = !source_value[rjl_pkg::MODE_BIT] && source_value[rjl_pkg::ALIGN_BIT];
        end else begin
            // [RULE11] classic target not implemented
            addr_error = !source_value[rjl_pkg::MODE_BIT];
        end
    end

endmodule : rjl_target

/* File: core/rjl_unit.sv */
// register jump-and-link control unit, plain and barrier forms
`timescale 1ns/1ps

// Overview of operation
// [RULE1] link register gets jump address plus eight
// [RULE2] delay slot completes before program counter redirect
// [RULE3] target bit zero forced low when second set configured
// [RULE4] mode flag loads from source bit zero
// [RULE5] config zero: full value; else clear, update
// [RULE6] delay slot holds only long instructions
// [RULE7] source and link fields never equal
// [RULE8] delay slot exception restarts at jump
// [RULE9] software supplies correctly aligned targets
// [RULE10] classic target with bit one errors
// [RULE11] no classic set: even target errors
// [RULE12] no control transfer in delay slot
// [RULE13] barrier clears execution and instruction hazards
// [RULE14] barrier accepted in every operating mode
// [RULE15] delay slot hazards need not clear
// [RULE16] software clears hazard after code change
// [RULE17] barrier form decode fields and codes
// [RULE18] plain form decode fields and codes
module rjl_unit (
    input  wire logic        CLK,
    input  wire logic        RESETN,
    input  wire logic        ISSUE_VALID,
    input  wire logic [31:0] ISSUE_INSTR,
    input  wire logic [31:0] ISSUE_PC,
    input  wire logic [31:0] SOURCE_VALUE,
    input  wire logic        SECOND_SET_PRESENT_CFG,
    input  wire logic        CLASSIC_SET_PRESENT,
    input  wire logic        SLOT_DONE,
    input  wire logic        SLOT_EXCEPTION,
    output logic             ACCEPTED,
    output logic             BUSY,
    output logic             LINK_WRITE,
    output logic      [4:0]  LINK_SELECT,
    output logic      [31:0] LINK_DATA,
    output logic      [4:0]  SOURCE_SELECT,
    output logic             REDIRECT,
    output logic      [31:0] REDIRECT_PC,
    output logic             INSTR_SET_SELECT_FLAG,
    output logic             FETCH_ADDR_ERROR,
    output logic             HAZARD_CLEAR,
    output logic             RESTART,
    output logic      [31:0] RESTART_PC
);

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic rjl_match(input logic [31:0] word, input logic [9:0] minor);
        rjl_match = (word[rjl_pkg::MAJOR_MSB:rjl_pkg::MAJOR_LSB] == rjl_pkg::MAJOR_OPCODE_GROUP_A)
                 && (word[rjl_pkg::SEC_MSB:rjl_pkg::SEC_LSB] == rjl_pkg::MINOR_EXT_GROUP)
                 && (word[rjl_pkg::MINOR_MSB:rjl_pkg::MINOR_LSB] == minor);
    endfunction : rjl_match

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    rjl_pkg::rjl_state_t state;
    rjl_pkg::rjl_state_t next_state;

    logic        is_plain;
    logic        is_barrier;
    logic        take;
    logic        in_slot;
    logic        slot_fault;
    logic        slot_finish;

    logic [31:0] jump_pc;
    logic [31:0] next_jump_pc;
    logic [31:0] held_source;
    logic [31:0] next_held_source;
    logic        held_barrier;
    logic        next_held_barrier;

    logic [31:0] calc_target;
    logic        calc_mode_load;
    logic        calc_mode_value;
    logic        calc_addr_error;

    logic        next_accepted;
    logic        next_busy;
    logic        next_link_write;
    logic [4:0]  next_link_select;
    logic [31:0] next_link_data;
    logic [4:0]  next_source_select;
    logic        next_redirect;
    logic [31:0] next_redirect_pc;
    logic        next_instr_set_select_flag;
    logic        next_fetch_addr_error;
    logic        next_hazard_clear;
    logic        next_restart;
    logic [31:0] next_restart_pc;

    ////////////////////////////////////////////////////////////////////////////
    // instruction decode

    always_comb begin
        // [RULE18] plain form decode
        is_plain   = rjl_match(ISSUE_INSTR, rjl_pkg::MINOR_CALL_PLAIN);
        // [RULE17] barrier form decode
        // [RULE14] no privilege check here
        is_barrier = rjl_match(ISSUE_INSTR, rjl_pkg::MINOR_CALL_BARRIER);
        take       = ISSUE_VALID && (state == rjl_pkg::RJL_IDLE) && (is_plain || is_barrier);
    end

    ////////////////////////////////////////////////////////////////////////////
    // target computation on the held source value

    rjl_target u_target (
        .source_value           (held_source),
        .second_set_present_cfg (SECOND_SET_PRESENT_CFG),
        .classic_set_present    (CLASSIC_SET_PRESENT),
        .target                 (calc_target),
        .mode_load              (calc_mode_load),
        .mode_value             (calc_mode_value),
        .addr_error             (calc_addr_error)
    );

    ////////////////////////////////////////////////////////////////////////////
    // slot completion events

    always_comb begin
        in_slot     = (state == rjl_pkg::RJL_SLOT);
        // [RULE8] fault wins over completion
        slot_fault  = in_slot && SLOT_EXCEPTION;
        // [RULE2] redirect only after slot
        slot_finish = in_slot && !SLOT_EXCEPTION && SLOT_DONE;
    end

    ////////////////////////////////////////////////////////////////////////////
    // control state: next values

    always_comb begin
        next_state         = state;
        next_accepted      = 1'h0;
        next_busy          = BUSY;
        next_source_select = SOURCE_SELECT;
        case (state)
            rjl_pkg::RJL_IDLE: begin
                if (take) begin
                    next_state         = rjl_pkg::RJL_SLOT;
                    next_accepted      = 1'h1;
                    next_busy          = 1'h1;
                    next_source_select = ISSUE_INSTR[rjl_pkg::SRC_MSB:rjl_pkg::SRC_LSB];
                end
            end
            rjl_pkg::RJL_SLOT: begin
                if (slot_fault || slot_finish) begin
                    next_state = rjl_pkg::RJL_IDLE;
                    next_busy  = 1'h0;
                end
            end
            default: begin
                next_state = rjl_pkg::RJL_IDLE;
                next_busy  = 1'h0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // control state: registers

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            state         <= rjl_pkg::RJL_IDLE;
            ACCEPTED      <= 1'h0;
            BUSY          <= 1'h0;
            SOURCE_SELECT <= rjl_pkg::SEL_RESET;
        end else begin
            state         <= next_state;
            ACCEPTED      <= next_accepted;
            BUSY          <= next_busy;
            SOURCE_SELECT <= next_source_select;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // issue capture: next values

    always_comb begin
        next_jump_pc      = jump_pc;
        next_held_source  = held_source;
        next_held_barrier = held_barrier;
        if (take) begin
            next_jump_pc      = ISSUE_PC;
            // source sampled at issue
            next_held_source  = SOURCE_VALUE;
            next_held_barrier = is_barrier;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // issue capture: registers

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            jump_pc      <= rjl_pkg::ADDR_RESET;
            held_source  <= rjl_pkg::ADDR_RESET;
            held_barrier <= 1'h0;
        end else begin
            jump_pc      <= next_jump_pc;
            held_source  <= next_held_source;
            held_barrier <= next_held_barrier;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // return link: next values

    always_comb begin
        next_link_write  = 1'h0;
        next_link_select = LINK_SELECT;
        next_link_data   = LINK_DATA;
        if (take) begin
            // [RULE1] return link write
            next_link_write  = 1'h1;
            next_link_select = ISSUE_INSTR[rjl_pkg::LINK_MSB:rjl_pkg::LINK_LSB];
            next_link_data   = ISSUE_PC + rjl_pkg::LINK_OFFSET;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // return link: registers

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            LINK_WRITE  <= 1'h0;
            LINK_SELECT <= rjl_pkg::SEL_RESET;
            LINK_DATA   <= rjl_pkg::ADDR_RESET;
        end else begin
            LINK_WRITE  <= next_link_write;
            LINK_SELECT <= next_link_select;
            LINK_DATA   <= next_link_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // redirect: next values

    always_comb begin
        next_redirect              = 1'h0;
        next_redirect_pc           = REDIRECT_PC;
        next_instr_set_select_flag = INSTR_SET_SELECT_FLAG;
        next_fetch_addr_error      = 1'h0;
        next_hazard_clear          = 1'h0;
        if (slot_finish) begin
            // [RULE2] redirect after slot
            next_redirect    = 1'h1;
            next_redirect_pc = calc_target;
            // [RULE5] mode update when configured
            if (calc_mode_load) begin
                next_instr_set_select_flag = calc_mode_value;
            end
            // [RULE10] error flagged with target
            next_fetch_addr_error = calc_addr_error;
            // [RULE13] barrier clears hazards
            // [RULE15] issued with redirect only
            next_hazard_clear = held_barrier;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // redirect: registers

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            REDIRECT              <= 1'h0;
            REDIRECT_PC           <= rjl_pkg::ADDR_RESET;
            INSTR_SET_SELECT_FLAG <= rjl_pkg::INSTR_SET_SELECT_RESET;
            FETCH_ADDR_ERROR      <= 1'h0;
            HAZARD_CLEAR          <= 1'h0;
        end else begin
            REDIRECT              <= next_redirect;
            REDIRECT_PC           <= next_redirect_pc;
            INSTR_SET_SELECT_FLAG <= next_instr_set_select_flag;
            FETCH_ADDR_ERROR      <= next_fetch_addr_error;
            HAZARD_CLEAR          <= next_hazard_clear;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // restart: next values

    always_comb begin
        next_restart    = 1'h0;
        next_restart_pc = RESTART_PC;
        if (slot_fault) begin
            // [RULE8] resume at jump
            next_restart    = 1'h1;
            next_restart_pc = jump_pc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // restart: registers

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            RESTART    <= 1'h0;
            RESTART_PC <= rjl_pkg::ADDR_RESET;
        end else begin
            RESTART    <= next_restart;
            RESTART_PC <= next_restart_pc;
        end
    end

endmodule : rjl_unit

/* File: verification/rjl_unit_chk.sv */
// assertion checker for the register jump-and-link unit
`timescale 1ns/1ps
module rjl_unit_chk (
    input wire logic        CLK,
    input wire logic        RESETN,
    input wire logic        ISSUE_VALID,
    input wire logic [31:0] ISSUE_INSTR,
    input wire logic [31:0] ISSUE_PC,
    input wire logic [31:0] SOURCE_VALUE,
    input wire logic        SECOND_SET_PRESENT_CFG,
    input wire logic        CLASSIC_SET_PRESENT,
    input wire logic        SLOT_DONE,
    input wire logic        SLOT_EXCEPTION,
    input wire logic        ACCEPTED,
    input wire logic        BUSY,
    input wire logic        LINK_WRITE,
    input wire logic [31:0] LINK_DATA,
    input wire logic        REDIRECT,
    input wire logic [31:0] REDIRECT_PC,
    input wire logic        INSTR_SET_SELECT_FLAG,
    input wire logic        FETCH_ADDR_ERROR,
    input wire logic        HAZARD_CLEAR,
    input wire logic        RESTART,
    input wire logic [31:0] RESTART_PC
);
    logic [31:0] src_q;
    logic [31:0] pc_q;
    logic        hb_q;
    logic        take;
    logic        done;
    // a matching word offered while idle
    assign take = ISSUE_VALID && !BUSY && ISSUE_INSTR[31:26] == 6'h00 && ISSUE_INSTR[5:0] == 6'h3c
                  && (ISSUE_INSTR[15:6] == 10'h03c || ISSUE_INSTR[15:6] == 10'h07c);
    assign done = BUSY && SLOT_DONE && !SLOT_EXCEPTION;
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            src_q <= 32'h0;
            pc_q  <= 32'h0;
            hb_q  <= 1'h0;
        end else if (take) begin
            src_q <= SOURCE_VALUE;
            pc_q  <= ISSUE_PC;
            hb_q  <= ISSUE_INSTR[15:6] == 10'h07c;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    a_accept_decode: assert property (take |=> ACCEPTED && BUSY)
        else $error("decoded jump not accepted");
    a_link_value: assert property (ACCEPTED |-> LINK_WRITE && LINK_DATA == $past(ISSUE_PC) + 32'h8)
        else $error("link value wrong");
    a_redirect_due: assert property (done |=> REDIRECT && !BUSY)
        else $error("redirect late after slot");
    a_slot_first: assert property (REDIRECT |-> $past(done))
        else $error("redirect before slot done");
    a_target_value: assert property (REDIRECT |-> REDIRECT_PC ==
        ($past(SECOND_SET_PRESENT_CFG) ? {src_q[31:1], 1'b0} : src_q)) else $error("target wrong");
    a_mode_load: assert property (REDIRECT && $past(SECOND_SET_PRESENT_CFG) |->
        INSTR_SET_SELECT_FLAG == src_q[0]) else $error("mode flag not loaded");
    a_mode_kept: assert property (REDIRECT && !$past(SECOND_SET_PRESENT_CFG) |->
        $stable(INSTR_SET_SELECT_FLAG)) else $error("mode flag changed");
    a_addr_error: assert property (REDIRECT |-> FETCH_ADDR_ERROR ==
        ($past(CLASSIC_SET_PRESENT) ? !src_q[0] && src_q[1] : !src_q[0])) else $error("address error wrong");
    a_hazard_form: assert property (HAZARD_CLEAR == (REDIRECT && hb_q))
        else $error("hazard clear wrong");
    a_restart_jump: assert property (BUSY && SLOT_EXCEPTION |=> RESTART && !REDIRECT && RESTART_PC == pc_q)
        else $error("restart wrong");
    c_barrier: cover property (REDIRECT && HAZARD_CLEAR);
    c_restart: cover property (RESTART);
    c_addr_err: cover property (FETCH_ADDR_ERROR);
endmodule : rjl_unit_chk
bind rjl_unit rjl_unit_chk i_chk (.*);

/* File: verification/rjl_pipe_model.sv */
// delay slot completion model for the pipeline beyond the jump unit
`timescale 1ns/1ps
module rjl_pipe_model (
    input  wire logic       clk,
    input  wire logic       busy,
    input  wire logic [3:0] delay,
    input  wire logic       fault,
    output logic            slot_done,
    output logic            slot_exc
);
    logic [4:0] waited = 5'h0;
    initial begin
        slot_done = 1'b0;
        slot_exc  = 1'b0;
    end
    // one plain slot instruction, completing once
    always @(negedge clk) begin
        slot_done <= busy && waited == {1'b0, delay} && !fault;
        slot_exc  <= busy && waited == {1'b0, delay} && fault;
        waited    <= busy ? waited + 5'h1 : 5'h0;
    end
endmodule : rjl_pipe_model

/* File: verification/register_jump_link_unit_tb.sv */
// self-checking bench for the register jump-and-link unit
`timescale 1ns/1ps
module register_jump_link_unit_tb;
    logic clk = 0, resetn = 0, valid = 0, cfg = 0, cls = 0, flt = 0, exp_flag = 0;
    logic [31:0] instr = 32'h0, pc = 32'h0, src = 32'h0, link_data, redirect_pc, restart_pc;
    logic [3:0] dly = 4'h0;
    logic [4:0] link_sel, src_sel;
    logic accepted, busy, link_write, redirect, flag, addr_err, hazard, restart, slot_done, slot_exc;
    int err_total = 0, samples_checked = 0, cycles = 0;
    always #12.5 clk = ~clk;
    rjl_unit i_dut (.CLK(clk), .RESETN(resetn), .ISSUE_VALID(valid), .ISSUE_INSTR(instr), .ISSUE_PC(pc),
        .SOURCE_VALUE(src), .SECOND_SET_PRESENT_CFG(cfg), .CLASSIC_SET_PRESENT(cls), .SLOT_DONE(slot_done),
        .SLOT_EXCEPTION(slot_exc), .ACCEPTED(accepted), .BUSY(busy), .LINK_WRITE(link_write),
        .LINK_SELECT(link_sel), .LINK_DATA(link_data), .SOURCE_SELECT(src_sel), .REDIRECT(redirect),
        .REDIRECT_PC(redirect_pc), .INSTR_SET_SELECT_FLAG(flag), .FETCH_ADDR_ERROR(addr_err),
        .HAZARD_CLEAR(hazard), .RESTART(restart), .RESTART_PC(restart_pc));
    rjl_pipe_model i_pipe (.clk(clk), .busy(busy), .delay(dly), .fault(flt), .slot_done(slot_done),
        .slot_exc(slot_exc));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (exp !== got) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    function automatic logic [31:0] word(input logic hb);
        return {6'h00, 5'h05, 5'h0a, hb ? 10'h07c : 10'h03c, 6'h3c};
    endfunction : word
    // issue in the current cycle, then follow the jump to completion
    task automatic jump(input logic hb, c, k, f, input logic [31:0] p, s, input logic [3:0] d);
        int n;
        n = 0;
        valid = 1; instr = word(hb); pc = p; src = s; cfg = c; cls = k; flt = f; dly = d;
        @(negedge clk);
        valid = 0; src = ~s;
        chk("accepted", 1, accepted);
        chk("link_data", p + 32'h8, link_data);
        chk("link_select", 6'h25, {link_write, link_sel});
        chk("source_select", 5'h0a, src_sel);
        while (!(redirect || restart) && n < 20) begin
            @(negedge clk);
            n++;
        end
        chk("slot_wait", d + 1, n);
        if (f) chk("restart_pc", p, restart_pc);
        else begin
            if (c) exp_flag = s[0];
            chk("redirect_pc", c ? {s[31:1], 1'b0} : s, redirect_pc);
            chk("mode_flag", exp_flag, flag);
            chk("addr_error", k ? (!s[0] && s[1]) : !s[0], addr_err);
            chk("hazard_clear", hb, hazard);
        end
    endtask : jump
    task automatic s_targets();
        jump(0, 0, 1, 0, 32'h0000_1000, 32'h0000_2001, 4'h0);
        jump(1, 1, 1, 0, 32'h0000_1100, 32'h0000_4003, 4'h2);
    endtask : s_targets
    task automatic s_addr_errors();
        logic [31:0] sv [3] = '{32'h0000_6002, 32'h0000_6004, 32'h0000_6005};
        logic cl [3] = '{1'b1, 1'b0, 1'b0};
        // targets probe misaligned classic, even non-classic and odd non-classic cases
        for (int i = 0; i < 3; i++) jump(i[0], 1, cl[i], 0, 32'h0000_1200, sv[i], 4'h1);
    endtask : s_addr_errors
    task automatic s_slot_fault();
        jump(1, 1, 1, 1, 32'h0000_1300, 32'h0000_5001, 4'h3);
        jump(0, 0, 1, 0, 32'h0000_1300, 32'h0000_5001, 4'h0);
    endtask : s_slot_fault
    task automatic s_refuse();
        valid = 1; instr = 32'h0000_0bfc; pc = 32'h0000_3000; src = 32'h0000_3000; flt = 0; dly = 4'h4;
        @(negedge clk);
        chk("odd_word_accepted", 0, accepted);
        instr = word(0);
        @(negedge clk);
        pc = 32'h0000_3100;
        @(negedge clk);
        valid = 0;
        chk("busy_accepted", 0, accepted);
        chk("busy_link", 32'h0000_3008, link_data);
        for (int i = 0; i < 10 && !redirect; i++) @(negedge clk);
        chk("refuse_redirect", 32'h0000_3000, redirect_pc);
    endtask : s_refuse
    always @(posedge clk) begin
        cycles++;
        if (cycles == 500) begin
            err_total++;
            final_report();
        end
    end
    initial begin
        repeat (6) @(negedge clk);
        resetn = 1;
        chk("reset_outputs", 0, {accepted, busy, redirect, restart, flag});
        s_targets();
        s_addr_errors();
        s_slot_fault();
        @(negedge clk);
        s_refuse();
        final_report();
    end
endmodule : register_jump_link_unit_tb
